// ---- src/mde_consts.svh ----
`ifndef MDE_CONSTS_SVH
`define MDE_CONSTS_SVH
`define MDE_OP_DIV        16'hF000
`define MDE_OP_MUL        16'hE000
`define MDE_EXT_PREFIX    9'h018
`define MDE_MUL_CYC_16    5'h0A
`define MDE_MUL_CYC_18    5'h0B
`define MDE_DIV_MIN_16    5'h0A
`define MDE_DIV_MAX_16    5'h0E
`define MDE_EXT_EXTRA     5'h01
`define MDE_CFG_EXTRA     5'h01
`define MDE_SHORT_CYC     5'h03
`define MDE_INCR_CYC      5'h04
`define MDE_MEM_CYCLE_NS  1800
`define MDE_CLK_NS        20
`define MDE_MEM_CLKS      ((`MDE_MEM_CYCLE_NS + `MDE_CLK_NS - 1) / `MDE_CLK_NS)
`define MDE_MUL_TIME_NS   18000
`define MDE_DIV_MAX_NS    25200
`define MDE_DIV_OVF_Q     16'h8000
`endif

// ---- src/mde_pkg.sv ----
package mde_pkg;
	typedef enum logic [3:0] {
		MDE_NONE      = 4'h0,
		MDE_MUL       = 4'h1,
		MDE_DIV       = 4'h2,
		MDE_LOAD_A    = 4'h3,
		MDE_LOAD_B    = 4'h4,
		MDE_LOAD_X    = 4'h5,
		MDE_STORE_A   = 4'h6,
		MDE_STORE_B   = 4'h7,
		MDE_STORE_X   = 4'h8,
		MDE_INCR      = 4'h9,
		MDE_ADD       = 4'hA,
		MDE_SUB       = 4'hB,
		MDE_OR        = 4'hC,
		MDE_XOR       = 4'hD,
		MDE_AND       = 4'hE
	} mde_op_t;
	typedef enum logic [1:0] {
		MDE_IDLE = 2'b00,
		MDE_RUN  = 2'b01,
		MDE_DONE = 2'b10
	} mde_state_t;
endpackage : mde_pkg

// ---- src/mde_decode.sv ----
`timescale 1ns/100ps
`include "mde_consts.svh"
module mde_decode
	import mde_pkg::*;
(
	input  wire logic [15:0] instr_i,
	output mde_op_t          op_o,
	output logic             ext_o,
	output logic [2:0]       mode_digit_o
);
	// **************************************
	// opcode decode
	// **************************************
	always_comb begin
		op_o = MDE_NONE;
		ext_o = 1'b0;
		mode_digit_o = instr_i[2:0];
		if (instr_i == `MDE_OP_DIV) begin
			op_o = MDE_DIV;
		end else if (instr_i == `MDE_OP_MUL) begin
			op_o = MDE_MUL;
		end else if (instr_i[15:7] == `MDE_EXT_PREFIX) begin
			ext_o = 1'b1;
			unique case ({instr_i[6], instr_i[5:3]})
				4'h1: op_o = MDE_LOAD_A;
				4'h2: op_o = MDE_LOAD_B;
				4'h3: op_o = MDE_LOAD_X;
				4'h4: op_o = MDE_INCR;
				4'h5: op_o = MDE_STORE_A;
				4'h6: op_o = MDE_STORE_B;
				4'h7: op_o = MDE_STORE_X;
				4'h9: op_o = MDE_OR;
				4'hA: op_o = MDE_ADD;
				4'hB: op_o = MDE_XOR;
				4'hC: op_o = MDE_SUB;
				4'hD: op_o = MDE_AND;
				4'hE: op_o = MDE_MUL;
				4'hF: op_o = MDE_DIV;
				default: begin
					op_o = MDE_NONE;
					ext_o = 1'b0;
				end
			endcase
		end
	end
endmodule : mde_decode

// ---- src/mde_unit.sv ----
`timescale 1ns/100ps
`include "mde_consts.svh"
module mde_unit
	import mde_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        start_i,
	input  wire logic [15:0] instr_i,
	input  wire logic [15:0] addr_word_i,
	input  wire logic        cfg18_i,
	input  wire logic        mem_cycle_i,
	input  wire logic [15:0] mem_rdata_i,
	input  wire logic [15:0] acc_a_i,
	input  wire logic [15:0] acc_b_i,
	input  wire logic [15:0] idx_x_i,
	output logic             busy_o,
	output logic             done_o,
	output logic             illegal_o,
	output logic [15:0]      eff_addr_o,
	output logic [2:0]       mode_digit_o,
	output logic [15:0]      acc_a_o,
	output logic [15:0]      acc_b_o,
	output logic [15:0]      idx_x_o,
	output logic             wr_a_o,
	output logic             wr_b_o,
	output logic             wr_x_o,
	output logic             mem_we_o,
	output logic [15:0]      mem_wdata_o
);
	// **************************************
	// decode
	// **************************************
	mde_op_t    op_w;
	logic       ext_w;
	logic [2:0] digit_w;
	mde_decode u_dec (
		.instr_i      (instr_i),
		.op_o         (op_w),
		.ext_o        (ext_w),
		.mode_digit_o (digit_w)
	);

	mde_state_t  state_r;
	mde_op_t     op_r;
	logic [4:0]  cyc_r;
	logic [4:0]  target_r;
	logic [15:0] opnd_r;
	logic        have_r;
	logic        cfg_r;
	logic        ext_r;
	logic [15:0] a_r;
	logic [15:0] b_r;
	logic [15:0] x_r;

	// **************************************
	// arithmetic
	// **************************************
	logic signed [31:0] prod_w;
	logic signed [31:0] sum_w;
	logic signed [31:0] dvd_w;
	logic signed [31:0] quo_w;
	logic signed [31:0] rem_w;
	logic               ovf_w;
	logic [3:0]         div_extra_w;
	always_comb begin
		prod_w = $signed(b_r) * $signed(opnd_r);
		sum_w = prod_w + 32'($signed(a_r));
		dvd_w = $signed({a_r, b_r});
		quo_w = 32'h0000_0000;
		rem_w = 32'h0000_0000;
		ovf_w = 1'b0;
		if (opnd_r == 16'h0000) begin
			ovf_w = 1'b1;
		end else begin
			quo_w = dvd_w / 32'($signed(opnd_r));
			rem_w = dvd_w % 32'($signed(opnd_r));
			ovf_w = (quo_w > 32'sh0000_7FFF) || (quo_w < -32'sh0000_8000);
		end
		// operand-dependent extra cycles, 0..4
		div_extra_w = {1'b0, 3'(a_r[15] ^ opnd_r[15]) + 3'(a_r[0]) + 3'(b_r[0])}
			+ {3'h0, ovf_w};
	end

	// **************************************
	// sequencer
	// **************************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= MDE_IDLE;
			op_r <= MDE_NONE;
			ext_r <= 1'b0;
			cfg_r <= 1'b0;
			cyc_r <= 5'h00;
			target_r <= 5'h00;
			have_r <= 1'b0;
		end else begin
			unique case (state_r)
				MDE_IDLE: begin
					if (start_i && op_w != MDE_NONE) begin
						state_r <= MDE_RUN;
						op_r <= op_w;
						ext_r <= ext_w;
						cfg_r <= cfg18_i;
						cyc_r <= 5'h00;
						have_r <= 1'b0;
					end
				end
				MDE_RUN: begin
					if (mem_cycle_i) begin
						cyc_r <= cyc_r + 5'h01;
						if (cyc_r == 5'h00) begin
							have_r <= 1'b1;
						end
						if (cyc_r + 5'h01 >= target_r) begin
							state_r <= MDE_DONE;
						end
					end
				end
				MDE_DONE: begin
					state_r <= MDE_IDLE;
				end
				default: state_r <= MDE_IDLE;
			endcase
			if (state_r == MDE_IDLE) begin
				target_r <= `MDE_SHORT_CYC;
			end else if (have_r) begin
				unique case (op_r)
					MDE_MUL: target_r <= `MDE_MUL_CYC_16
						+ (cfg_r ? `MDE_CFG_EXTRA : 5'h00)
						+ (ext_r ? `MDE_EXT_EXTRA : 5'h00);
					MDE_DIV: target_r <= `MDE_DIV_MIN_16 + {1'b0, div_extra_w}
						+ (cfg_r ? `MDE_CFG_EXTRA : 5'h00)
						+ (ext_r ? `MDE_EXT_EXTRA : 5'h00);
					MDE_INCR: target_r <= `MDE_INCR_CYC;
					default: target_r <= `MDE_SHORT_CYC;
				endcase
			end
		end
	end

	// register capture at start, operand capture on first memory cycle
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			opnd_r <= 16'h0000;
			a_r <= 16'h0000;
			b_r <= 16'h0000;
			x_r <= 16'h0000;
			eff_addr_o <= 16'h0000;
			mode_digit_o <= 3'h0;
			illegal_o <= 1'b0;
		end else if (state_r == MDE_IDLE && start_i) begin
			a_r <= acc_a_i;
			b_r <= acc_b_i;
			x_r <= idx_x_i;
			eff_addr_o <= addr_word_i;
			mode_digit_o <= digit_w;
			illegal_o <= (op_w == MDE_NONE);
		end else if (state_r == MDE_RUN && mem_cycle_i && cyc_r == 5'h00) begin
			opnd_r <= mem_rdata_i;
		end
	end

	// **************************************
	// results
	// **************************************
	logic [15:0] sum16_w;
	always_comb begin
		sum16_w = 16'h0000;
		unique case (op_r)
			MDE_ADD: sum16_w = a_r + opnd_r;
			MDE_SUB: sum16_w = a_r - opnd_r;
			MDE_INCR: sum16_w = opnd_r + 16'h0001;
			default: sum16_w = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			acc_a_o <= 16'h0000;
			acc_b_o <= 16'h0000;
			idx_x_o <= 16'h0000;
			wr_a_o <= 1'b0;
			wr_b_o <= 1'b0;
			wr_x_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_wdata_o <= 16'h0000;
			done_o <= 1'b0;
		end else begin
			wr_a_o <= 1'b0;
			wr_b_o <= 1'b0;
			wr_x_o <= 1'b0;
			mem_we_o <= 1'b0;
			done_o <= 1'b0;
			if (state_r == MDE_DONE) begin
				done_o <= 1'b1;
				unique case (op_r)
					MDE_MUL: begin
						acc_a_o <= sum_w[31:16];
						acc_b_o <= sum_w[15:0];
						wr_a_o <= 1'b1;
						wr_b_o <= 1'b1;
					end
					MDE_DIV: begin
						// fixed result when quotient cannot fit
						acc_b_o <= ovf_w ? `MDE_DIV_OVF_Q : quo_w[15:0];
						acc_a_o <= ovf_w ? a_r : rem_w[15:0];
						wr_a_o <= 1'b1;
						wr_b_o <= 1'b1;
					end
					MDE_LOAD_A: begin
						acc_a_o <= opnd_r;
						wr_a_o <= 1'b1;
					end
					MDE_LOAD_B: begin
						acc_b_o <= opnd_r;
						wr_b_o <= 1'b1;
					end
					MDE_LOAD_X: begin
						idx_x_o <= opnd_r;
						wr_x_o <= 1'b1;
					end
					MDE_STORE_A: begin
						mem_wdata_o <= a_r;
						mem_we_o <= 1'b1;
					end
					MDE_STORE_B: begin
						mem_wdata_o <= b_r;
						mem_we_o <= 1'b1;
					end
					MDE_STORE_X: begin
						mem_wdata_o <= x_r;
						mem_we_o <= 1'b1;
					end
					MDE_INCR: begin
						mem_wdata_o <= sum16_w;
						mem_we_o <= 1'b1;
					end
					MDE_ADD, MDE_SUB: begin
						acc_a_o <= sum16_w;
						wr_a_o <= 1'b1;
					end
					MDE_OR: begin
						acc_a_o <= a_r | opnd_r;
						wr_a_o <= 1'b1;
					end
					MDE_XOR: begin
						acc_a_o <= a_r ^ opnd_r;
						wr_a_o <= 1'b1;
					end
					MDE_AND: begin
						acc_a_o <= a_r & opnd_r;
						wr_a_o <= 1'b1;
					end
					default: done_o <= 1'b1;
				endcase
			end
		end
	end

	assign busy_o = (state_r != MDE_IDLE);
endmodule : mde_unit

// ---- test/mde_unit_checker.sv ----
`timescale 1ns/100ps
module mde_unit_checker
	import mde_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        start_i,
	input wire logic [15:0] instr_i,
	input wire logic [15:0] addr_word_i,
	input wire logic        cfg18_i,
	input wire logic        mem_cycle_i,
	input wire logic        busy_o,
	input wire logic        done_o,
	input wire logic        illegal_o,
	input wire logic [15:0] eff_addr_o,
	input wire logic [2:0]  mode_digit_o,
	input wire logic [15:0] acc_a_o,
	input wire logic [15:0] acc_b_o,
	input wire logic [15:0] idx_x_o,
	input wire logic        wr_a_o,
	input wire logic        wr_b_o,
	input wire logic        wr_x_o,
	input wire logic        mem_we_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// ****************
	// expected count window
	// ****************
	logic       ext;
	logic [3:0] k;
	logic [4:0] lo_f, hi_f, n_r, lo_r, hi_r;
	assign ext = instr_i[15:7] == 9'h018;
	assign k = instr_i[6:3];
	always_comb begin
		lo_f = 5'h03;
		if (instr_i == 16'hE000 || (ext && k == 4'hE) || instr_i == 16'hF000 || (ext && k == 4'hF))
			lo_f = 5'h0A + {4'h0, ext} + {4'h0, cfg18_i};
		else if (k == 4'h4)
			lo_f = 5'h04;
		hi_f = (instr_i == 16'hF000 || (ext && k == 4'hF)) ? lo_f + 5'h04 : lo_f;
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			n_r <= 5'h00;
			lo_r <= 5'h00;
			hi_r <= 5'h00;
		end else if (start_i && !busy_o) begin
			n_r <= 5'h00;
			lo_r <= lo_f;
			hi_r <= hi_f;
		end else if (busy_o && mem_cycle_i)
			n_r <= n_r + 5'h01;
	end
	// ****************
	// properties
	// ****************
	done_pulse_a: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
	strobe_done_a: assert property ((wr_a_o || wr_b_o || wr_x_o || mem_we_o) |-> done_o)
		else $error("strobe without done");
	eff_addr_a: assert property (start_i && !busy_o |=> (busy_o |-> eff_addr_o == $past(addr_word_i)))
		else $error("effective address not second word");
	mode_digit_a: assert property (start_i && !busy_o |=> (busy_o |-> mode_digit_o == $past(instr_i[2:0])))
		else $error("mode digit altered");
	cycle_count_a: assert property (done_o |-> n_r >= lo_r && n_r <= hi_r)
		else $error("memory cycle count wrong");
	done_bound_a: assert property ($rose(busy_o) |-> ##[1:150] done_o) else $error("no done");
	illegal_idle_a: assert property ($rose(illegal_o) |-> !busy_o) else $error("illegal op ran");
	result_hold_a: assert property (!$stable({acc_a_o, acc_b_o, idx_x_o}) |-> done_o)
		else $error("result changed without done");
	cover property (done_o && wr_x_o);
	cover property (done_o && mem_we_o);
	cover property ($rose(illegal_o));
endmodule : mde_unit_checker
bind mde_unit mde_unit_checker i_chk (.*);

// ---- test/mde_mem_model.sv ----
`timescale 1ns/100ps
module mde_mem_model (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        slow_i,
	input wire logic [15:0] operand_i,
	output logic            mem_cycle_o,
	output logic [15:0]     mem_rdata_o
);
	logic [2:0] cnt_r;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			cnt_r <= 3'h0;
		else if (cnt_r == (slow_i ? 3'h6 : 3'h2))
			cnt_r <= 3'h0;
		else
			cnt_r <= cnt_r + 3'h1;
	end
	assign mem_cycle_o = (cnt_r == 3'h0) && !reset_i;
	// word valid only in its cycle
	assign mem_rdata_o = mem_cycle_o ? operand_i : ~operand_i;
endmodule : mde_mem_model

// ---- test/mde_unit_tb.sv ----
`timescale 1ns/100ps
module mde_unit_tb;
	import mde_pkg::*;
	logic        clk_i = 1'b0, reset_i = 1'b1, start_i = 1'b0, cfg18 = 1'b0, slow = 1'b0;
	logic [15:0] ins = 16'h0000, ad = 16'h0000, a = 16'h0000, b = 16'h0000, x = 16'h0000;
	logic [15:0] m = 16'h0000, ea, ra, rb, rx, wd, rd;
	logic        mc, busy, done, ill, wa, wb, wx, we;
	logic [2:0]  md;
	int          n_mismatch = 0, samples_checked = 0;
	logic [3:0]  kl[12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
	always #10 clk_i = ~clk_i;
	mde_mem_model i_mem (.clk_i(clk_i), .reset_i(reset_i), .slow_i(slow), .operand_i(m),
		.mem_cycle_o(mc), .mem_rdata_o(rd));
	mde_unit i_dut (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .instr_i(ins),
		.addr_word_i(ad), .cfg18_i(cfg18), .mem_cycle_i(mc), .mem_rdata_i(rd), .acc_a_i(a),
		.acc_b_i(b), .idx_x_i(x), .busy_o(busy), .done_o(done), .illegal_o(ill),
		.eff_addr_o(ea), .mode_digit_o(md), .acc_a_o(ra), .acc_b_o(rb), .idx_x_o(rx),
		.wr_a_o(wa), .wr_b_o(wb), .wr_x_o(wx), .mem_we_o(we), .mem_wdata_o(wd));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic run(input logic [15:0] i, input logic [15:0] w);
		@(negedge clk_i);
		ins = i;
		m = w;
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		for (int n = 0; n < 200 && done !== 1'b1; n++)
			@(negedge clk_i);
		chk({15'h0, done}, 16'h0001);
	endtask : run
	task automatic t_mul();
		a = 16'h0005;
		b = 16'hFFFD;
		run(16'hE000, 16'h0007);
		chk(ra, 16'hFFFF);
		chk(rb, 16'hFFF0);
		chk({14'h0, wa, wb}, 16'h0003);
		a = 16'h0000;
		b = 16'h8000;
		cfg18 = 1'b1;
		ad = 16'h7ABC;
		run(16'h0C75, 16'h8000);
		chk(ra, 16'h4000);
		chk(rb, 16'h0000);
		chk(ea, 16'h7ABC);
		chk({13'h0, md}, 16'h0005);
		$display("mul test end");
	endtask : t_mul
	task automatic t_div();
		slow = 1'b1;
		a = 16'h0000;
		b = 16'h0064;
		run(16'hF000, 16'h0007);
		chk(rb, 16'h000E);
		chk(ra, 16'h0002);
		a = 16'h0001;
		b = 16'h0000;
		run(16'h0C78, 16'h0100);
		chk(rb, 16'h0100);
		chk(ra, 16'h0000);
		a = 16'h1234;
		run(16'hF000, 16'h0000);
		chk(rb, 16'h8000);
		chk(ra, 16'h1234);
		slow = 1'b0;
		cfg18 = 1'b0;
		$display("div test end");
	endtask : t_div
	task automatic t_ext();
		a = 16'h00F0;
		b = 16'h0F0F;
		x = 16'h1234;
		foreach (kl[i]) begin
			run({9'h018, kl[i], 3'h2}, 16'h3C3C);
			chk({15'h0, we}, {15'h0, kl[i] inside {4'h4, 4'h5, 4'h6, 4'h7}});
			chk({15'h0, wx}, {15'h0, kl[i] == 4'h3});
			case (kl[i])
				4'h1: chk(ra, 16'h3C3C);
				4'h2: chk(rb, 16'h3C3C);
				4'h3: chk(rx, 16'h3C3C);
				4'h4: chk(wd, 16'h3C3D);
				4'h5: chk(wd, 16'h00F0);
				4'h6: chk(wd, 16'h0F0F);
				4'h7: chk(wd, 16'h1234);
				4'h9: chk(ra, 16'h3CFC);
				4'hA: chk(ra, 16'h3D2C);
				4'hB: chk(ra, 16'h3CCC);
				4'hC: chk(ra, 16'hC4B4);
				default: chk(ra, 16'h0030);
			endcase
		end
		$display("ext test end");
	endtask : t_ext
	task automatic t_bad();
		for (int i = 0; i < 2; i++) begin
			@(negedge clk_i);
			ins = i ? 16'h0000 : 16'h0C40;
			start_i = 1'b1;
			@(negedge clk_i);
			start_i = 1'b0;
			@(negedge clk_i);
			chk({14'h0, ill, busy}, 16'h0002);
		end
		$display("illegal test end");
	endtask : t_bad
	initial begin
		repeat (16) @(negedge clk_i);
		reset_i = 1'b0;
		repeat (2) @(negedge clk_i);
		t_mul();
		t_div();
		t_ext();
		t_bad();
		stop_test();
	end
	initial begin
		#1000000;
		n_mismatch++;
		stop_test();
	end
endmodule : mde_unit_tb
